/* File: hdl/edma_pkg.sv */
/*
  Shared constants for the descriptor list control block: register
  offsets, field positions, reset values, soft reset length and the
  channel state encoding.
  Assumes a byte-addressed register port with 32-bit aligned words.
*/
package edma_pkg;

    // register byte offsets
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] TX_GO_OFS = 8'h08;
    localparam logic [7:0] RX_GO_OFS = 8'h10;
    localparam logic [7:0] TX_BASE_OFS = 8'h18;
    localparam logic [7:0] RX_BASE_OFS = 8'h20;
    localparam logic [7:0] STAT_OFS = 8'h24;

    // field positions
    localparam int GO_BIT = 0;
    localparam int SWR_BIT = 0;
    localparam int DL_LSB = 4;
    localparam int ST_TX_READY = 0;
    localparam int ST_RX_READY = 1;
    localparam int ST_RX_FAULT = 2;
    localparam int ST_SWR_BUSY = 3;

    // values after reset and encodings
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [1:0] DL_RST = 2'h0;
    localparam logic [1:0] DL_PROHIB = 2'h3;
    localparam logic [6:0] DESC_MIN_LEN = 7'h10;

    // soft reset length in bus clock cycles
    localparam int SWR_CYCLES = 64;

    typedef enum logic [2:0]
    {
        CH_IDLE = 3'b001,
        CH_FETCH = 3'b010,
        CH_SERVE = 3'b100
    } ch_state_t;

endpackage

/* File: hdl/swr_timer.sv */
/*
  Soft reset timer: a start pulse holds the busy flag for a fixed
  number of bus clock cycles, then it drops by itself.
  Assumes a synchronised active-low reset.
*/
`timescale 1ns/10ps
module swr_timer
    import edma_pkg::*;
#(
    parameter int CYCLES = SWR_CYCLES
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_start,
    output logic o_busy_r
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;

    if (CYCLES < 1)
    begin : g_chk
        $error("swr_timer needs at least one cycle");
    end

    // busy for exactly CYCLES cycles after a start
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_busy_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (i_start && !o_busy_r)
        begin
            o_busy_r <= 1'b1;
            cnt_r <= CW'(CYCLES - 1);
        end
        else if (o_busy_r)
        begin
            if (cnt_r == '0)
                o_busy_r <= 1'b0;
            else
                cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule // swr_timer

/* File: hdl/desc_channel.sv */
/*
  One descriptor list walker: fetches the descriptor at the current
  pointer, serves it while active, advances by one descriptor length
  when the partner reports the buffer done, halts on an inactive one.
  Assumes the owner arbitrates the shared fetch port.
*/
`timescale 1ns/10ps
module desc_channel
    import edma_pkg::*;
#(
    parameter int STOPPABLE = 0
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_srst,
    // control from registers
    input wire logic i_go,
    input wire logic i_load,
    input wire logic [31:0] i_base,
    input wire logic [6:0] i_len,
    // fetch port
    input wire logic i_ack,
    input wire logic i_active,
    output logic o_req,
    output logic o_halt,
    output logic [31:0] o_ptr,
    // partner side
    input wire logic i_done,
    output logic o_serve_r,
    output logic o_start_r
);
    ch_state_t state_r;
    ch_state_t state_nxt;
    logic stop;

    if (STOPPABLE > 1)
    begin : g_chk
        $error("desc_channel STOPPABLE must be 0 or 1");
    end

    assign stop = (STOPPABLE == 1) && !i_go;
    assign o_req = (state_r == CH_FETCH);
    assign o_halt = (state_r == CH_FETCH) && i_ack && !i_active && !stop;

    // next state of the walk
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CH_IDLE:
                if (i_go)
                    state_nxt = CH_FETCH;
            CH_FETCH:
                if (stop)
                    state_nxt = CH_IDLE;
                else if (i_ack)
                    state_nxt = i_active ? CH_SERVE : CH_IDLE;
            CH_SERVE:
                if (stop)
                    state_nxt = CH_IDLE;
                else if (i_done)
                    state_nxt = CH_FETCH;
            default:
                state_nxt = CH_IDLE;
        endcase
    end

    // state, serve level and start pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= CH_IDLE;
            o_serve_r <= 1'b0;
            o_start_r <= 1'b0;
        end
        else if (i_srst)
        begin
            state_r <= CH_IDLE;
            o_serve_r <= 1'b0;
            o_start_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            o_serve_r <= (state_nxt == CH_SERVE);
            o_start_r <= (state_r == CH_FETCH) && (state_nxt == CH_SERVE);
        end
    end

    // pointer: reload from base, step one descriptor per buffer
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_ptr <= REG_RST;
        else if (i_srst || i_load)
            o_ptr <= i_base;
        else if (state_r == CH_SERVE && i_done && !stop)
            o_ptr <= o_ptr + {25'h0, i_len};
    end

endmodule // desc_channel

/* File: hdl/ether_dma_desc_list_control.sv */
/*
  Descriptor list control of the ethernet dma unit: request bits,
  list bases, descriptor size and soft reset, one list walker per
  direction and a shared descriptor fetch port.
  Assumes the mac core and memory logic run on i_clk_sys, so their
  inputs need no synchronising; i_arst_n is asynchronous.
*/
// Operation
// R1: writing 1 to send_go_bit fetches current tx descriptor, sends if active.
// R2: after each sent frame, fetch next tx descriptor, continue while active.
// R3: inactive tx descriptor clears send_go_bit and halts transmit channel.
// R4: writing 0 to send_go_bit does not stop transmission.
// R5: receive_go_bit set fetches rx descriptor; active one makes engine ready.
// R6: after a receive buffer fills, fetch next rx descriptor for next frame.
// R7: inactive rx descriptor clears receive_go_bit and halts receive channel.
// R8: receive_go_bit at 0 disables the receive function.
// R9: clearing reception mid-frame corrupts pointers; soft reset needed to recover.
// R10: software stops mac_rx_enable, awaits write-back, then clears receive_go_bit.
// R11: tx_list_base low bits zero per descriptor size: 4, 5 or 6.
// R12: rx_list_base low bits zero per descriptor size: 4, 5 or 6.
// R13: tx_list_base written only while send_go_bit reads 0.
// R14: rx_list_base written only while receive_go_bit reads 0.
// R15: bits 31 to 1 of both request registers read as zero.
// R16: descriptor_size_field 00/01/10 gives 16/32/64 bytes; 11 prohibited.
// R17: soft_reset_bit resets engine except bases for 64 cycles, self-clears.
`timescale 1ns/10ps
module ether_dma_desc_list_control
    import edma_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // descriptor fetch port
    output logic o_fetch_req,
    output logic [31:0] o_fetch_addr,
    input wire logic i_fetch_ack,
    input wire logic i_fetch_active,
    // mac core, transmit
    output logic o_tx_start,
    input wire logic i_tx_done,
    // mac core, receive
    output logic o_rx_ready,
    input wire logic i_rx_buf_done,
    input wire logic i_rx_frame_busy,
    // mac core reset
    output logic o_mac_srst
);
    logic rst_sync_r;
    logic rst_n_r;
    logic srst;
    logic wr_ok;
    logic swr_start;
    logic [1:0] dl_r;
    logic [6:0] desc_len;
    logic tx_go_r;
    logic rx_go_r;
    logic rx_fault_r;
    logic [31:0] tx_base_r;
    logic [31:0] rx_base_r;
    logic tx_load_r;
    logic rx_load_r;
    logic gnt_rx_r;
    logic tx_req;
    logic rx_req;
    logic tx_ack;
    logic rx_ack;
    logic tx_halt;
    logic rx_halt;
    logic [31:0] tx_ptr;
    logic [31:0] rx_ptr;
    logic tx_serve;
    logic rx_serve;
    logic tx_start;
    logic rx_start;
    logic [31:0] rd_val;

    // reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_sync_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_sync_r <= 1'b1;
            rst_n_r <= rst_sync_r;
        end
    end

    // writes refused while the soft reset runs
    assign wr_ok = i_wr && !srst;
    assign swr_start = wr_ok && (i_addr == MODE_OFS) && i_wdata[SWR_BIT];

    // soft reset period
    swr_timer #(
        .CYCLES(SWR_CYCLES)
    ) u_swr (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_r),
        .i_start(swr_start), // [R17]
        .o_busy_r(srst)
    );

    // descriptor size field, prohibited code keeps old value
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            dl_r <= DL_RST;
        else if (srst)
            dl_r <= DL_RST; // [R17]
        else if (wr_ok && i_addr == MODE_OFS &&
                 i_wdata[DL_LSB+1:DL_LSB] != DL_PROHIB)
            dl_r <= i_wdata[DL_LSB+1:DL_LSB]; // [R16]
    end

    // 16, 32 or 64 bytes
    assign desc_len = DESC_MIN_LEN << dl_r; // [R16]

    // send-go: software sets, an inactive descriptor or the soft reset clears
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            tx_go_r <= 1'b0;
        else if (srst)
            tx_go_r <= 1'b0; // [R17]
        else if (wr_ok && i_addr == TX_GO_OFS && i_wdata[GO_BIT])
            tx_go_r <= 1'b1; // [R1] [R4]
        else if (tx_halt)
            tx_go_r <= 1'b0; // [R3]
    end

    // receive-go: software writes either way, inactive descriptor clears
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            rx_go_r <= 1'b0;
        else if (srst)
            rx_go_r <= 1'b0; // [R17]
        else if (wr_ok && i_addr == RX_GO_OFS)
            rx_go_r <= i_wdata[GO_BIT]; // [R5] [R8]
        else if (rx_halt)
            rx_go_r <= 1'b0; // [R7]
    end

    // receive disabled mid-frame: pointers no longer trusted
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            rx_fault_r <= 1'b0;
        else if (srst)
            rx_fault_r <= 1'b0; // [R9]
        else if (wr_ok && i_addr == RX_GO_OFS && !i_wdata[GO_BIT] &&
                 rx_go_r && i_rx_frame_busy)
            rx_fault_r <= 1'b1; // [R9]
    end

    // list bases survive the soft reset
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_base_r <= REG_RST;
            rx_base_r <= REG_RST;
            tx_load_r <= 1'b0;
            rx_load_r <= 1'b0;
        end
        else
        begin
            tx_load_r <= wr_ok && (i_addr == TX_BASE_OFS);
            rx_load_r <= wr_ok && (i_addr == RX_BASE_OFS);
            if (wr_ok && i_addr == TX_BASE_OFS)
                tx_base_r <= i_wdata;
            if (wr_ok && i_addr == RX_BASE_OFS)
                rx_base_r <= i_wdata;
        end
    end

    // shared fetch port, transmit first
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_fetch_req <= 1'b0;
            o_fetch_addr <= REG_RST;
            gnt_rx_r <= 1'b0;
        end
        else if (!o_fetch_req)
        begin
            if (tx_req)
            begin
                o_fetch_req <= 1'b1;
                o_fetch_addr <= tx_ptr;
                gnt_rx_r <= 1'b0;
            end
            else if (rx_req)
            begin
                o_fetch_req <= 1'b1;
                o_fetch_addr <= rx_ptr;
                gnt_rx_r <= 1'b1;
            end
        end
        else if (i_fetch_ack)
            o_fetch_req <= 1'b0;
    end

    assign tx_ack = i_fetch_ack && o_fetch_req && !gnt_rx_r;
    assign rx_ack = i_fetch_ack && o_fetch_req && gnt_rx_r;

    // transmit walker, software can stop it only through the soft reset
    desc_channel #(
        .STOPPABLE(0)
    ) u_tx (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_r),
        .i_srst(srst),
        .i_go(tx_go_r), // [R1]
        .i_load(tx_load_r),
        .i_base(tx_base_r),
        .i_len(desc_len),
        .i_ack(tx_ack),
        .i_active(i_fetch_active),
        .o_req(tx_req),
        .o_halt(tx_halt),
        .o_ptr(tx_ptr),
        .i_done(i_tx_done), // [R2]
        .o_serve_r(tx_serve),
        .o_start_r(tx_start)
    );

    // receive walker, dropped when receive-go falls or pointers broke
    desc_channel #(
        .STOPPABLE(1)
    ) u_rx (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_r),
        .i_srst(srst),
        .i_go(rx_go_r && !rx_fault_r), // [R8] [R9]
        .i_load(rx_load_r),
        .i_base(rx_base_r),
        .i_len(desc_len),
        .i_ack(rx_ack),
        .i_active(i_fetch_active),
        .o_req(rx_req),
        .o_halt(rx_halt),
        .o_ptr(rx_ptr),
        .i_done(i_rx_buf_done), // [R6]
        .o_serve_r(rx_serve),
        .o_start_r(rx_start)
    );

    assign o_tx_start = tx_start;
    assign o_rx_ready = rx_serve;
    assign o_mac_srst = srst;

    // read mux, unused bits zero
    always_comb
    begin
        rd_val = REG_RST;
        case (i_addr)
            MODE_OFS:
                rd_val[DL_LSB+1:DL_LSB] = dl_r;
            TX_GO_OFS:
                rd_val[GO_BIT] = tx_go_r; // [R15]
            RX_GO_OFS:
                rd_val[GO_BIT] = rx_go_r; // [R15]
            TX_BASE_OFS:
                rd_val = tx_base_r;
            RX_BASE_OFS:
                rd_val = rx_base_r;
            STAT_OFS:
            begin
                rd_val[ST_TX_READY] = tx_serve;
                rd_val[ST_RX_READY] = rx_serve;
                rd_val[ST_RX_FAULT] = rx_fault_r;
                rd_val[ST_SWR_BUSY] = srst;
            end
            default:
                rd_val = REG_RST;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
            o_rdata <= REG_RST;
        else
            o_rdata <= i_rd ? rd_val : REG_RST;
    end

    // checks on the walk and the registers
    a_tx_go_fetch: // [R1]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        $rose(tx_go_r) && !srst |-> ##[0:2] tx_req)
    else $error("send-go did not lead to a descriptor fetch");

    a_tx_active_start: // [R1]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        tx_ack && i_fetch_active && !srst |=> o_tx_start ##1 !o_tx_start)
    else $error("active tx descriptor gave no single start pulse");

    a_tx_next_desc: // [R2]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        tx_serve && i_tx_done && !srst |=>
        tx_req && tx_ptr == $past(tx_ptr) + {25'h0, $past(desc_len)})
    else $error("tx did not step to the next descriptor");

    a_tx_halt_clear: // [R3]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        tx_ack && !i_fetch_active && !srst && !swr_start &&
        !(i_wr && i_addr == TX_GO_OFS && i_wdata[GO_BIT])
        |=> !tx_go_r && !tx_serve)
    else $error("inactive tx descriptor did not halt transmit");

    a_tx_zero_ignored: // [R4]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        tx_go_r && wr_ok && i_addr == TX_GO_OFS && !i_wdata[GO_BIT] &&
        !tx_halt && !swr_start |=> tx_go_r)
    else $error("writing 0 stopped transmission");

    a_rx_active_ready: // [R5]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        rx_ack && i_fetch_active && rx_go_r && !rx_fault_r && !srst &&
        !(i_wr && i_addr == RX_GO_OFS) |=> o_rx_ready)
    else $error("active rx descriptor did not make receive ready");

    a_rx_next_desc: // [R6]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        rx_serve && i_rx_buf_done && rx_go_r && !rx_fault_r && !srst
        |=> !o_rx_ready ##0 $changed(rx_ptr))
    else $error("rx did not move to the next descriptor");

    a_rx_halt_clear: // [R7]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        rx_halt && !srst && !i_wr |=> !rx_go_r ##1 !o_rx_ready)
    else $error("inactive rx descriptor did not halt receive");

    a_rx_disabled: // [R8]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        !rx_go_r |=> !o_rx_ready)
    else $error("receive ready while receive-go is 0");

    a_rx_fault_set: // [R9]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        rx_go_r && wr_ok && i_addr == RX_GO_OFS && !i_wdata[GO_BIT] &&
        i_rx_frame_busy |=> rx_fault_r until srst)
    else $error("mid-frame receive stop not flagged");

    a_go_reserved: // [R15]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        i_rd && (i_addr == TX_GO_OFS || i_addr == RX_GO_OFS)
        |=> o_rdata[31:1] == 31'h0)
    else $error("reserved request bits read nonzero");

    a_swr_length: // [R17]
    assert property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        $rose(srst) |-> ##63 srst ##1 !srst && !tx_go_r && !rx_go_r)
    else $error("soft reset did not last 64 cycles");

endmodule // ether_dma_desc_list_control

/* File: dv/mac_mem_model.sv */
/*
  Far-side model: descriptor memory plus mac core transmit and receive.
  Assumes the bench bounds the active descriptors by end addresses.
*/
`timescale 1ns/10ps
module mac_mem_model
(
    // clock
    input wire logic i_clk_sys,
    // bench control
    input wire logic [31:0] i_tx_end,
    input wire logic [31:0] i_rx_end,
    input wire logic [3:0] i_ack_wait,
    input wire logic i_feed,
    // block side
    input wire logic i_fetch_req,
    input wire logic [31:0] i_fetch_addr,
    input wire logic i_tx_start,
    input wire logic i_rx_ready,
    output logic o_fetch_ack,
    output logic o_fetch_active,
    output logic o_tx_done,
    output logic o_rx_buf_done,
    output logic o_rx_frame_busy
);
    logic [3:0] wait_r;
    logic [2:0] tx_r;
    logic [2:0] rx_r;
    logic hit;

    initial
    begin
        wait_r = 4'h0;
        tx_r = 3'h0;
        rx_r = 3'h0;
        o_fetch_ack = 1'b0;
        o_fetch_active = 1'b0;
    end

    assign hit = i_fetch_req && !o_fetch_ack && wait_r >= i_ack_wait;

    // memory: one-cycle ack after a chosen wait, flag valid only with it
    always @(posedge i_clk_sys)
    begin
        wait_r <= (i_fetch_req && !o_fetch_ack) ? wait_r + 4'h1 : 4'h0;
        o_fetch_ack <= hit;
        if (hit)
            o_fetch_active <= (i_fetch_addr[31:28] == 4'h1) ?
                i_fetch_addr < i_tx_end : i_fetch_addr < i_rx_end;
        else
            o_fetch_active <= ~o_fetch_active; // no stale flag
    end

    // transmit: frame ends six cycles after its start pulse
    always @(posedge i_clk_sys)
        tx_r <= i_tx_start ? 3'h1 : (tx_r != 3'h0 ? tx_r + 3'h1 : 3'h0);
    assign o_tx_done = tx_r == 3'h6;

    // receive: a frame only while ready, then wait for ready to drop
    always @(posedge i_clk_sys)
        if (rx_r == 3'h0)
            rx_r <= {2'h0, i_rx_ready && i_feed};
        else if (rx_r != 3'h5 || !i_rx_ready)
            rx_r <= (rx_r == 3'h5) ? 3'h0 : rx_r + 3'h1;
    assign o_rx_frame_busy = rx_r inside {3'h1, 3'h2, 3'h3};
    assign o_rx_buf_done = rx_r == 3'h4;
endmodule // mac_mem_model

/* File: dv/testbench.sv */
/*
  Self-checking bench for the descriptor list control block.
  Assumes the far-side model answers fetches and frames.
*/
`timescale 1ns/10ps
module testbench;
    import edma_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] tx_end = 32'h0;
    logic [31:0] rx_end = 32'h0;
    logic [3:0] ack_wait = 4'h0;
    logic feed = 1'b0;
    logic rd_pend = 1'b0;
    logic [31:0] rdata, fetch_addr;
    logic fetch_req, fetch_ack, fetch_active, tx_start, tx_done;
    logic rx_ready, rx_buf_done, rx_frame_busy, mac_srst;
    logic [31:0] rd_q[$];
    logic [31:0] fa_q[$];
    int fails = 0;
    int checks = 0;
    int starts = 0;
    int srst_cycles = 0;
    int seed = 48005;
    logic [7:0] ofs_list[7] = '{MODE_OFS, TX_GO_OFS, RX_GO_OFS,
        TX_BASE_OFS, RX_BASE_OFS, STAT_OFS, 8'h3C};

    ether_dma_desc_list_control ether_dma_desc_list_control_i (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
        .i_fetch_ack(fetch_ack), .i_fetch_active(fetch_active),
        .o_tx_start(tx_start), .i_tx_done(tx_done), .o_rx_ready(rx_ready),
        .i_rx_buf_done(rx_buf_done), .i_rx_frame_busy(rx_frame_busy),
        .o_mac_srst(mac_srst));
    mac_mem_model mac_mem_model_i (
        .i_clk_sys(clk_sys), .i_tx_end(tx_end), .i_rx_end(rx_end),
        .i_ack_wait(ack_wait), .i_feed(feed), .i_fetch_req(fetch_req),
        .i_fetch_addr(fetch_addr), .i_tx_start(tx_start),
        .i_rx_ready(rx_ready), .o_fetch_ack(fetch_ack),
        .o_fetch_active(fetch_active), .o_tx_done(tx_done),
        .o_rx_buf_done(rx_buf_done), .o_rx_frame_busy(rx_frame_busy));

    always #25 clk_sys = ~clk_sys;

    task automatic cmp_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp,
        input logic got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask

    task automatic wait_fetch();
        for (int k = 0; k < 3000 && fa_q.size() != 0; k++)
            @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
        cmp_word("fetches left", 32'h0, 32'(fa_q.size()));
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchers: frame and soft reset counts, read data, fetch addresses
    always @(posedge clk_sys)
    begin
        rd_pend <= rd;
        starts <= starts + int'(tx_start);
        srst_cycles <= srst_cycles + int'(mac_srst);
    end

    always @(negedge clk_sys)
    begin
        if (rd_pend)
            cmp_word("read data", rd_q.pop_front(), rdata);
        if (fetch_req && fetch_ack)
            cmp_word("fetch address", fa_q.pop_front(), fetch_addr);
    end

    initial
    begin
        #(50 * 40000);
        fails++;
        $display("timeout");
        complete_run();
    end

    // main sequence
    initial
    begin
        logic [31:0] base;
        logic [31:0] txb;
        logic [31:0] len;
        int st0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        foreach (ofs_list[i])
            rd_reg(ofs_list[i], REG_RST);
        for (int s = 0; s < 3; s++)
        begin
            len = 32'h10 << s;
            ack_wait <= 4'($random(seed) & 3);
            wr_reg(MODE_OFS, 32'(s) << DL_LSB);
            rd_reg(MODE_OFS, 32'(s) << DL_LSB);
            txb = {4'h1, 28'($random(seed))} & 32'hF7FF_FFC0;
            tx_end <= txb + 3 * len;
            wr_reg(TX_BASE_OFS, txb);
            rd_reg(TX_BASE_OFS, txb);
            for (int k = 0; k < 4; k++)
                fa_q.push_back(txb + k * len);
            st0 = starts;
            wr_reg(TX_GO_OFS, 32'h1);
            rd_reg(TX_GO_OFS, 32'h1);
            wr_reg(TX_GO_OFS, 32'h0);
            rd_reg(TX_GO_OFS, 32'h1);
            wait_fetch();
            rd_reg(TX_GO_OFS, REG_RST);
            cmp_word("frames sent", 32'h3, 32'(starts - st0));
            base = {4'h2, 28'($random(seed))} & 32'hF7FF_FFC0;
            rx_end <= base + 2 * len;
            feed <= 1'b1;
            wr_reg(RX_BASE_OFS, base);
            for (int k = 0; k < 3; k++)
                fa_q.push_back(base + k * len);
            wr_reg(RX_GO_OFS, 32'h1);
            rd_reg(RX_GO_OFS, 32'h1);
            wait_fetch();
            rd_reg(RX_GO_OFS, REG_RST);
        end
        // prohibited size code leaves the field as it was
        wr_reg(MODE_OFS, 32'h30);
        rd_reg(MODE_OFS, 32'h20);
        // stop reception only when no frame is arriving
        feed <= 1'b0;
        rx_end <= 32'hFFFF_FFFF;
        // walker halted on the last rx descriptor, refetches it
        fa_q.push_back(base + 2 * len);
        wr_reg(RX_GO_OFS, 32'h1);
        for (int k = 0; k < 100 && rx_ready !== 1'b1; k++)
            @(negedge clk_sys);
        cmp_flag("receive ready", 1'b1, rx_ready);
        wr_reg(RX_GO_OFS, 32'h0);
        repeat (2) @(negedge clk_sys);
        cmp_flag("receive ready", 1'b0, rx_ready);
        // receive dropped mid-frame: fault flag until soft reset
        feed <= 1'b1;
        fa_q.push_back(base + 2 * len);
        wr_reg(RX_GO_OFS, 32'h1);
        for (int k = 0; k < 100 && rx_frame_busy !== 1'b1; k++)
            @(negedge clk_sys);
        wr_reg(RX_GO_OFS, 32'h0);
        rd_reg(STAT_OFS, 32'h4);
        feed <= 1'b0;
        // soft reset: length, ignored writes, kept bases, cleared state
        wr_reg(RX_GO_OFS, 32'h1);
        wr_reg(MODE_OFS, 32'h21);
        wr_reg(TX_BASE_OFS, 32'h3000_0000);
        rd_reg(TX_BASE_OFS, txb);
        rd_reg(STAT_OFS, 32'h8);
        repeat (80) @(posedge clk_sys);
        cmp_word("soft reset cycles", SWR_CYCLES, 32'(srst_cycles));
        cmp_flag("receive ready", 1'b0, rx_ready);
        rd_reg(MODE_OFS, REG_RST);
        rd_reg(RX_GO_OFS, REG_RST);
        rd_reg(RX_BASE_OFS, base);
        // pointer back at the base, inactive there, channel halts
        tx_end <= txb;
        fa_q.push_back(txb);
        wr_reg(TX_GO_OFS, 32'h1);
        wait_fetch();
        rd_reg(TX_GO_OFS, REG_RST);
        repeat (4) @(posedge clk_sys);
        complete_run();
    end
endmodule // testbench
